/* rtl/input_image_pkg.sv */
// Package: constants and carrier types for the eight-channel input image.
// Assumes a single 250 MHz core clock domain.
package input_image_pkg;
  // ----------------------------------------------------------------------
  // Geometry and addressing
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 8;
  localparam logic [7:0] INPUT_STATE_BYTE_OFFSET = 8'h00;
  localparam logic [7:0] INPUT_STATE_BYTE_RESET = 8'h00;
  localparam logic [15:0] CANOPEN_OBJECT_INDEX = 16'h6000;
  localparam logic [15:0] ETHERCAT_INDEX_BASE = 16'h6000;
  localparam logic [7:0] ETHERCAT_FIRST_SUBINDEX = 8'h01;
  localparam logic [7:0] ETHERCAT_LAST_SUBINDEX = 8'h08;
  // Arbitrary module identity value, not a real part code
  localparam logic [31:0] MODULE_IDENTITY = 32'h0000_0a01;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned INPUT_DELAY_US = 3000;
  localparam int unsigned INPUT_DELAY_CYCLES =
    (INPUT_DELAY_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned DELAY_CNT_W = 20;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_FIELDBUS = 2'b00,
    ACC_CANOPEN  = 2'b01,
    ACC_ETHERCAT = 2'b10
  } access_mode_e;

  typedef struct packed {
    logic req;
    access_mode_e mode;
    logic [7:0] offset;
    logic [15:0] object_index;
    logic [7:0] object_subindex;
    logic [7:0] slot;
  } read_req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } read_rsp_s;

  typedef struct packed {
    logic run_indicator;
    logic module_fault_indicator;
  } module_led_s;
endpackage : input_image_pkg

/* rtl/input_channel_filter.sv */
// Holds one input channel's delay filter.
// Assumes the raw input is already synchronised to core_clk.
`timescale 1ns/100ps
`default_nettype none
module input_channel_filter
  import input_image_pkg::*;
#(
  // Full hardware delay by default; a bench may shorten it
  parameter int unsigned DELAY_CYCLES = INPUT_DELAY_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Channel
  input wire logic raw_in,
  output logic filtered_q
);
  import input_image_pkg::*;

  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST =
    DELAY_CNT_W'(DELAY_CYCLES - 1);

  logic [DELAY_CNT_W-1:0] stable_cnt_q;

  // -----------------------------------------------------------------------
  // Stability counter
  // -----------------------------------------------------------------------
  // Any bounce restarts the full wait, both directions alike
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_cnt_q <= '0;
    end else if (raw_in == filtered_q) begin
      stable_cnt_q <= '0;
    end else if (stable_cnt_q != DELAY_LAST) begin
      stable_cnt_q <= stable_cnt_q + 1'b1;
    end else begin
      stable_cnt_q <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filtered_q <= 1'b0;
    end else if (raw_in != filtered_q && stable_cnt_q == DELAY_LAST) begin
      filtered_q <= raw_in;
    end
  end
endmodule : input_channel_filter
`default_nettype wire

/* rtl/input_image_core.sv */
// Eight-channel digital input image: filter, pack, indicate, answer reads.
// Assumes the coupler issues one-cycle read strobes on core_clk.
//
// Overview of operation
// - Eight separate binary inputs are reported together and shown one LED each.
// - The input byte sits at offset +0 with bit n the filtered channel n.
// - Through a CANopen coupler the byte is the object at index 6000h.
// - Through EtherCAT the index is 6000h plus slot, subindex 01h..08h is channel 0..7.
// - Each channel reports a change only after 3 ms, both directions.
// - A channel's green LED is lit while its input is one, dark at zero.
// - The red fault LED is lit while module status reports an error.
// - The green run LED is on while backplane communication and bus supply both work, else off.
// - No output-area byte is used; only the input byte is exchanged.
`timescale 1ns/100ps
`default_nettype none
module input_image_core
#(
  // Full hardware delay by default; a bench may shorten it
  parameter int unsigned DELAY_CYCLES = input_image_pkg::INPUT_DELAY_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Field inputs (asynchronous)
  input wire logic [7:0] input_channel_n,
  // Backplane read access
  input wire input_image_pkg::read_req_s rd_req,
  output var input_image_pkg::read_rsp_s rd_rsp,
  // Module status from the backplane side
  input wire logic bus_comm_ok,
  input wire logic bus_supply_ok,
  input wire logic module_error,
  // Indicators
  output logic [7:0] channel_led,
  output var input_image_pkg::module_led_s module_led
);
  import input_image_pkg::*;

  // -----------------------------------------------------------------------
  // Synchronisers
  // -----------------------------------------------------------------------
  logic [7:0] in_meta_q;
  logic [7:0] in_sync_q;
  logic [2:0] stat_meta_q;
  logic [2:0] stat_sync_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= 8'h00;
      in_sync_q <= 8'h00;
    end else begin
      in_meta_q <= input_channel_n;
      in_sync_q <= in_meta_q;
    end
  end

  // Status lines may come from another supply domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_meta_q <= 3'h0;
      stat_sync_q <= 3'h0;
    end else begin
      stat_meta_q <= {bus_comm_ok, bus_supply_ok, module_error};
      stat_sync_q <= stat_meta_q;
    end
  end

  // -----------------------------------------------------------------------
  // Per-channel filters
  // -----------------------------------------------------------------------
  logic [7:0] filtered;

  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    input_channel_filter #(.DELAY_CYCLES(DELAY_CYCLES)) u_filter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .raw_in(in_sync_q[ch]),
      .filtered_q(filtered[ch])
    );
  end

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  function automatic logic [8:0] decode_read(input read_req_s r,
                                             input logic [7:0] img);
    logic hit;
    logic [7:0] data;
    logic [15:0] idx;
    logic [7:0] sub;
    hit = 1'b0;
    data = 8'h00;
    idx = ETHERCAT_INDEX_BASE + {8'h00, r.slot};
    sub = r.object_subindex - ETHERCAT_FIRST_SUBINDEX;
    case (r.mode)
      ACC_FIELDBUS: begin
        // Output area and higher offsets are not ours
        if (r.offset == INPUT_STATE_BYTE_OFFSET) begin
          hit = 1'b1;
          data = img;
        end
      end
      ACC_CANOPEN: begin
        if (r.object_index == CANOPEN_OBJECT_INDEX) begin
          hit = 1'b1;
          data = img;
        end
      end
      ACC_ETHERCAT: begin
        if (r.object_index == idx &&
            r.object_subindex >= ETHERCAT_FIRST_SUBINDEX &&
            r.object_subindex <= ETHERCAT_LAST_SUBINDEX) begin
          hit = 1'b1;
          data = {7'h00, img[sub[2:0]]};
        end
      end
      default: begin
        hit = 1'b0;
        data = 8'h00;
      end
    endcase
    return {hit, data};
  endfunction : decode_read

  logic [8:0] dec;
  assign dec = decode_read(rd_req, filtered);

  // -----------------------------------------------------------------------
  // Read answer
  // -----------------------------------------------------------------------
  // Misses answer with hit low and zero data, never stall the coupler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_rsp <= '0;
    end else begin
      rd_rsp.valid <= rd_req.req;
      rd_rsp.hit <= rd_req.req & dec[8];
      rd_rsp.data <= rd_req.req ? dec[7:0] : INPUT_STATE_BYTE_RESET;
    end
  end

  // -----------------------------------------------------------------------
  // Indicators
  // -----------------------------------------------------------------------
  // LEDs follow the reported state, so they share the filter delay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_led <= 8'h00;
    end else begin
      channel_led <= filtered;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_led <= '0;
    end else begin
      module_led.run_indicator <= stat_sync_q[2] & stat_sync_q[1];
      module_led.module_fault_indicator <= stat_sync_q[0];
    end
  end
endmodule : input_image_core
`default_nettype wire

/* testbench/input_image_properties.sv */
// Checker: port relations of the input image core.
// Assumes a bind onto input_image_core, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module input_image_properties
  import input_image_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [7:0] input_channel_n,
  input wire input_image_pkg::read_req_s rd_req,
  input wire input_image_pkg::read_rsp_s rd_rsp,
  input wire logic bus_comm_ok,
  input wire logic bus_supply_ok,
  input wire logic module_error,
  input wire logic [7:0] channel_led,
  input wire input_image_pkg::module_led_s module_led
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic byte_hit, bit_hit;
  assign byte_hit = rd_req.req && (rd_req.mode == ACC_FIELDBUS ?
    rd_req.offset == 8'h00 : rd_req.mode == ACC_CANOPEN &&
    rd_req.object_index == 16'h6000);
  assign bit_hit = rd_req.req && rd_req.mode == ACC_ETHERCAT &&
    rd_req.object_index == 16'h6000 + {8'h00, rd_req.slot} &&
    rd_req.object_subindex inside {[8'h01:8'h08]};
  answer_next_a: assert property (rd_req.req |=> rd_rsp.valid)
    else $error("read not answered");
  quiet_idle_a: assert property (!rd_req.req |=> rd_rsp == '0)
    else $error("answer without read");
  byte_read_a: assert property (byte_hit |=>
    rd_rsp.hit && rd_rsp.data == channel_led) else $error("byte read");
  bit_read_a: assert property (bit_hit |=> rd_rsp.hit &&
    rd_rsp.data == {7'h00, channel_led[$past(rd_req.object_subindex[2:0])
    - 3'h1]}) else $error("channel read");
  miss_read_a: assert property (rd_req.req && !byte_hit && !bit_hit
    |=> !rd_rsp.hit && rd_rsp.data == 8'h00) else $error("miss read");
  run_led_a: assert property ((bus_comm_ok && bus_supply_ok)[*3]
    |=> module_led.run_indicator) else $error("run led dark");
  fault_led_a: assert property (module_error[*3]
    |=> module_led.module_fault_indicator) else $error("fault led dark");
  // Depth 4 lands inside the long stable stretch before any update
  led_follow_a: assert property (((channel_led ^ $past(channel_led)) &
    ($past(input_channel_n, 4) ^ channel_led)) == 8'h00)
    else $error("led moved off input");
endmodule : input_image_properties
`default_nettype wire

/* testbench/backplane_coupler_model.sv */
// Coupler model: issues single reads to the input image.
// Assumes callers enter read just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module backplane_coupler_model
(
  // Clock
  input wire logic core_clk,
  // Read port
  output var input_image_pkg::read_req_s rd_req,
  input wire input_image_pkg::read_rsp_s rd_rsp
);
  initial rd_req = '0;
  // Released fields inverted so stale values never pass
  task automatic read(input logic [42:0] r, output logic [9:0] s);
    @(posedge core_clk);
    #1 rd_req = r;
    @(posedge core_clk);
    #1 s = rd_rsp;
    rd_req = {1'b0, ~r[41:0]};
  endtask : read
endmodule : backplane_coupler_model
`default_nettype wire

/* testbench/eight_channel_input_image_tb.sv */
// Bench: status, shortened 1000-cycle filter and reads of the input image.
// Assumes the coupler model and the checker bound below.
`timescale 1ns/100ps
`default_nettype none
module eight_channel_input_image_tb;
  import input_image_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] input_channel_n = 8'h00;
  logic [2:0] stat = 3'b000;
  read_req_s rd_req;
  read_rsp_s rd_rsp;
  logic [9:0] got;
  logic [7:0] channel_led;
  module_led_s module_led;
  int errors = 0, checks_done = 0, n = 0;
  // Shortened filter delay keeps the run small; same counter logic
  localparam int TB_DELAY = 1000;
  // Row: req+mode, offset, index, subindex, slot, then hit and data
  logic [51:0] rows [11] = '{{3'h4, 8'h00, 16'h0, 8'h0, 8'h0, 9'h1a5},
    {3'h4, 8'h01, 16'h0, 8'h0, 8'h0, 9'h0}, {3'h5, 8'h0, 16'h6000,
    8'h0, 8'h0, 9'h1a5}, {3'h5, 8'h0, 16'h6001, 8'h0, 8'h0, 9'h0},
    {3'h6, 8'h0, 16'h6003, 8'h01, 8'h03, 9'h101}, {3'h6, 8'h0, 16'h6003,
    8'h02, 8'h03, 9'h100}, {3'h6, 8'h0, 16'h6003, 8'h08, 8'h03, 9'h101},
    {3'h6, 8'h0, 16'h6003, 8'h00, 8'h03, 9'h0}, {3'h6, 8'h0, 16'h6003,
    8'h09, 8'h03, 9'h0}, {3'h6, 8'h0, 16'h6000, 8'h01, 8'h03, 9'h0},
    {3'h7, 8'h0, 16'h6000, 8'h0, 8'h0, 9'h0}};
  always #2 core_clk = ~core_clk;
  input_image_core #(.DELAY_CYCLES(TB_DELAY)) u_dut (.core_clk(core_clk),
    .rst_n(rst_n),
    .input_channel_n(input_channel_n), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .bus_comm_ok(stat[2]), .bus_supply_ok(stat[1]),
    .module_error(stat[0]), .channel_led(channel_led),
    .module_led(module_led));
  backplane_coupler_model u_coupler (.core_clk(core_clk),
    .rd_req(rd_req), .rd_rsp(rd_rsp));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : step
  task automatic report_and_stop();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_led(input logic [7:0] v);
    n = 0;
    while (channel_led !== v && n < TB_DELAY + 100) begin
      step(1);
      n++;
    end
    chk(10'(n inside {[TB_DELAY:TB_DELAY + 5]}), 10'h001);
    if (n >= TB_DELAY + 100) report_and_stop();
  endtask : wait_led
  initial begin
    step(8);
    rst_n = 1'b1;
    chk({module_led, channel_led}, 10'h000);
    foreach (rows[i]) begin
      stat = 3'(i);
      step(4);
      chk(10'(module_led), {8'h00, &i[2:1], i[0]});
    end
    stat = 3'b110;
    input_channel_n = 8'ha5;
    wait_led(8'ha5);
    foreach (rows[i]) begin
      u_coupler.read(rows[i][51:9], got);
      chk(got, {1'b1, rows[i][8:0]});
    end
    // A short bounce back must restart the whole wait
    input_channel_n = 8'h5a;
    step(TB_DELAY / 2);
    input_channel_n = 8'ha5;
    step(3);
    input_channel_n = 8'h5a;
    wait_led(8'h5a);
    rst_n = 1'b0;
    step(1);
    chk({rd_rsp.valid, 1'b0, channel_led}, 10'h000);
    report_and_stop();
  end
endmodule : eight_channel_input_image_tb
bind input_image_core input_image_properties u_props (.core_clk(core_clk),
  .rst_n(rst_n), .input_channel_n(input_channel_n), .rd_req(rd_req),
  .rd_rsp(rd_rsp), .bus_comm_ok(bus_comm_ok),
  .bus_supply_ok(bus_supply_ok), .module_error(module_error),
  .channel_led(channel_led), .module_led(module_led));
`default_nettype wire
